// >>> design/acs_sequencer.sv
// channel sequencer, setup selection and register file of the converter control
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [23:0] reg_wdata,
  input wire logic reg_rd,
  output logic [23:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic conv_done,
  input wire logic cal_done,
  input wire logic [23:0] cal_result,
  output logic converting,
  output logic [3:0] active_channel,
  output logic [4:0] positive_input_select,
  output logic [4:0] negative_input_select,
  output logic [2:0] active_setup,
  output logic [2:0] gain_select,
  output logic positive_buffer_on,
  output logic negative_buffer_on,
  output logic gain_stage_on,
  output logic [23:0] offset_coef,
  output logic [23:0] gain_coef
);
  logic [15:0] ctrl_q;
  logic [7:0] tally_q;
  logic [15:0] chan_q [16];
  logic [15:0] cfg_q [8];
  logic [3:0] cur_q;
  logic [3:0] cur_d;
  logic run_q;
  logic [3:0] mode;
  logic run_now;
  logic cal_zero;
  logic cal_full;
  logic [15:0] en_vec;
  logic any_en;
  logic [2:0] cur_setup;
  logic [15:0] cur_cfg;
  logic [2:0] cur_gain;
  logic offs_we;
  logic gain_we;
  logic [2:0] coef_waddr;
  logic [23:0] coef_wdata;
  logic [2:0] bus_setup;
  logic [23:0] offs_rd_a;
  logic [23:0] gain_rd_a;
  logic [23:0] rd_stage_q;
  logic [1:0] rd_sel_q;
  logic rd_stage_v_q;

  assign mode = ctrl_q[acs_pkg::CTRL_MODE_LSB +: 4];
  assign run_now = (mode == acs_pkg::MODE_CONT);
  assign cal_zero = (mode == acs_pkg::MODE_INT_ZERO) || (mode == acs_pkg::MODE_SYS_ZERO);
  assign cal_full = (mode == acs_pkg::MODE_INT_FULL) || (mode == acs_pkg::MODE_SYS_FULL);
  assign cur_setup = chan_q[cur_q][acs_pkg::CH_SETUP_LSB +: 3];
  assign cur_cfg = cfg_q[cur_setup];
  assign cur_gain = cur_cfg[acs_pkg::CFG_GAIN_LSB +: 3];
  assign bus_setup = reg_addr[2:0] - acs_pkg::OFFS_BASE[2:0];

  always_comb begin
    for (int i = 0; i < 16; i++) begin
      en_vec[i] = chan_q[i][acs_pkg::CH_EN_BIT];
    end
  end
  assign any_en = |en_vec;

  // next enabled channel above current, wrapping, itself if alone
  always_comb begin
    logic found;
    logic [3:0] idx;
    found = 1'b0;
    idx = 4'h0;
    cur_d = cur_q;
    for (int i = 1; i <= 16; i++) begin
      idx = 4'(cur_q + 4'(i));
      if (!found && en_vec[idx]) begin
        cur_d = idx;
        found = 1'b1;
      end
    end
  end

  // step on each finished conversion, restart at lowest enabled
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cur_q <= 4'h0;
      run_q <= 1'b0;
    end else begin
      run_q <= run_now && any_en;
      if (run_now && any_en && (!run_q || !en_vec[cur_q])) begin
        cur_q <= 4'h0;
        for (int i = 15; i >= 0; i--) begin
          if (en_vec[i]) begin
            cur_q <= 4'(i);
          end
        end
      end else if (run_q && conv_done) begin
        cur_q <= cur_d;
      end
    end
  end

  // control register; a finished calibration returns the mode to idle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_q <= acs_pkg::CTRL_RESET;
    end else if (cal_done && (cal_zero || cal_full)) begin
      ctrl_q[acs_pkg::CTRL_MODE_LSB +: 4] <= acs_pkg::MODE_IDLE;
    end else if (reg_wr && reg_addr == acs_pkg::CTRL_ADDR) begin
      ctrl_q <= reg_wdata[15:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tally_q <= acs_pkg::TALLY_RESET;
    end else begin
      tally_q <= tally_q + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) begin
        chan_q[i] <= acs_pkg::CHAN_RESET;
      end
    end else if (reg_wr && reg_addr >= acs_pkg::CHAN_BASE && reg_addr < acs_pkg::CFG_BASE) begin
      chan_q[4'(reg_addr - acs_pkg::CHAN_BASE)] <= reg_wdata[15:0] & acs_pkg::CH_WMASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        cfg_q[i] <= acs_pkg::CFG_RESET;
      end
    end else if (reg_wr && reg_addr >= acs_pkg::CFG_BASE && reg_addr < 6'(acs_pkg::CFG_BASE + 6'h08)) begin
      cfg_q[3'(reg_addr - acs_pkg::CFG_BASE)] <= reg_wdata[15:0] & acs_pkg::CFG_WMASK;
    end
  end

  // calibration result wins over a software write
  always_comb begin
    offs_we = 1'b0;
    gain_we = 1'b0;
    coef_waddr = bus_setup;
    coef_wdata = reg_wdata;
    if (cal_done && (cal_zero || cal_full)) begin
      offs_we = cal_zero;
      gain_we = cal_full;
      coef_waddr = cur_setup;
      coef_wdata = cal_result;
    end else if (reg_wr) begin
      offs_we = reg_addr >= acs_pkg::OFFS_BASE && reg_addr < acs_pkg::GAIN_BASE;
      gain_we = reg_addr >= acs_pkg::GAIN_BASE && reg_addr < 6'(acs_pkg::GAIN_BASE + 6'h08);
    end
  end

  acs_coef_mem #(.RESET_VALUE(acs_pkg::OFFS_RESET)) u_offs (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr_en(offs_we),
    .wr_addr(coef_waddr),
    .wr_data(coef_wdata),
    .rd_addr_a(bus_setup),
    .rd_data_a(offs_rd_a),
    .rd_addr_b(cur_setup),
    .rd_data_b(offset_coef)
  );

  acs_coef_mem #(.RESET_VALUE(acs_pkg::GAIN_RESET)) u_gain (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr_en(gain_we),
    .wr_addr(coef_waddr),
    .wr_data(coef_wdata),
    .rd_addr_a(bus_setup),
    .rd_data_a(gain_rd_a),
    .rd_addr_b(cur_setup),
    .rd_data_b(gain_coef)
  );

  // routing and front-end controls of the active channel
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      converting <= 1'b0;
      active_channel <= 4'h0;
      positive_input_select <= 5'h00;
      negative_input_select <= 5'h00;
      active_setup <= 3'h0;
      gain_select <= 3'h0;
      positive_buffer_on <= 1'b0;
      negative_buffer_on <= 1'b0;
      gain_stage_on <= 1'b0;
    end else begin
      converting <= run_q;
      active_channel <= cur_q;
      positive_input_select <= chan_q[cur_q][acs_pkg::CH_POS_LSB +: 5];
      negative_input_select <= chan_q[cur_q][acs_pkg::CH_NEG_LSB +: 5];
      active_setup <= cur_setup;
      gain_select <= cur_gain;
      positive_buffer_on <= cur_cfg[acs_pkg::CFG_BUFP_BIT] || (cur_gain != acs_pkg::GAIN_UNITY);
      negative_buffer_on <= cur_cfg[acs_pkg::CFG_BUFM_BIT] || (cur_gain != acs_pkg::GAIN_UNITY);
      gain_stage_on <= (cur_gain != acs_pkg::GAIN_UNITY);
    end
  end

  // register read, two cycles, unmapped reads give zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_stage_q <= 24'h000000;
      rd_sel_q <= 2'h0;
      rd_stage_v_q <= 1'b0;
      reg_rdata <= 24'h000000;
      reg_rvalid <= 1'b0;
    end else begin
      rd_stage_v_q <= reg_rd;
      rd_sel_q <= 2'h0;
      rd_stage_q <= 24'h000000;
      if (reg_addr == acs_pkg::CTRL_ADDR) begin
        rd_stage_q <= {8'h00, ctrl_q};
      end else if (reg_addr == acs_pkg::TALLY_ADDR) begin
        rd_stage_q <= {16'h0000, tally_q};
      end else if (reg_addr >= acs_pkg::CHAN_BASE && reg_addr < acs_pkg::CFG_BASE) begin
        rd_stage_q <= {8'h00, chan_q[4'(reg_addr - acs_pkg::CHAN_BASE)]};
      end else if (reg_addr >= acs_pkg::CFG_BASE && reg_addr < acs_pkg::OFFS_BASE - 6'h08) begin
        rd_stage_q <= {8'h00, cfg_q[3'(reg_addr - acs_pkg::CFG_BASE)]};
      end else if (reg_addr >= acs_pkg::OFFS_BASE && reg_addr < acs_pkg::GAIN_BASE) begin
        rd_sel_q <= 2'h1;
      end else if (reg_addr >= acs_pkg::GAIN_BASE && reg_addr < 6'(acs_pkg::GAIN_BASE + 6'h08)) begin
        rd_sel_q <= 2'h2;
      end
      reg_rvalid <= rd_stage_v_q;
      case (rd_sel_q)
        2'h1: reg_rdata <= offs_rd_a;
        2'h2: reg_rdata <= gain_rd_a;
        default: reg_rdata <= rd_stage_q;
      endcase
    end
  end

  // checks
  // free buffer choice at unity gain
  unity_buffers_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) && ($past(cur_gain) == acs_pkg::GAIN_UNITY) |->
      positive_buffer_on == $past(cur_cfg[acs_pkg::CFG_BUFP_BIT])
      && negative_buffer_on == $past(cur_cfg[acs_pkg::CFG_BUFM_BIT]))
    else $error("buffer enables do not follow setup at unity gain");
  forced_buffers_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (gain_select != 3'h0) |-> (positive_buffer_on && negative_buffer_on))
    else $error("buffers not forced on above unity gain");
  stage_bypass_a: assert property (@(posedge mclk) disable iff (!rst_n)
    gain_stage_on == (gain_select != 3'h0))
    else $error("gain stage state does not follow gain");
  tally_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) |-> tally_q == 8'($past(tally_q) + 8'h01))
    else $error("master clock tally did not advance");
  only_enabled_a: assert property (@(posedge mclk) disable iff (!rst_n)
    run_q && $stable(en_vec) && $past(run_q) |-> en_vec[cur_q])
    else $error("sequencer sits on a disabled channel");
  seq_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
    run_q && conv_done && en_vec[cur_q] && run_now && any_en |=> cur_q == $past(cur_d))
    else $error("sequencer did not step to next enabled channel");
  single_repeat_a: assert property (@(posedge mclk) disable iff (!rst_n)
    run_q && conv_done && run_now && $onehot(en_vec) && en_vec[cur_q] |=> $stable(cur_q))
    else $error("single enabled channel was left");
  route_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) |-> positive_input_select == $past(chan_q[cur_q][9:5])
      && negative_input_select == $past(chan_q[cur_q][4:0]))
    else $error("input routing does not follow the active channel");
  cal_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cal_done && cal_zero |-> offs_we && !gain_we && coef_waddr == cur_setup)
    else $error("zero-scale result not written to active setup offset");
  setup_pick_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) |-> active_setup == $past(chan_q[cur_q][14:12]))
    else $error("active setup does not follow channel setup field");
  offs_reset_a: assert property (@(posedge mclk)
    $past(!rst_n) && !rst_n |=> offset_coef == 24'h800000)
    else $error("offset coefficient did not reset to midscale");
  // read latency
  read_lat_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rd |-> ##2 reg_rvalid)
    else $error("read answer not two cycles after request");

  wrap_seen_c: cover property (@(posedge mclk) disable iff (!rst_n)
    run_q && conv_done && (cur_d < cur_q));
  cal_seen_c: cover property (@(posedge mclk) disable iff (!rst_n)
    cal_done && cal_full);
  gain_up_c: cover property (@(posedge mclk) disable iff (!rst_n)
    gain_stage_on && !cur_cfg[acs_pkg::CFG_BUFP_BIT]);
endmodule
`default_nettype wire

// >>> design/acs_pkg.sv
// constants shared by the channel sequencer and setup logic
package acs_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 24;
  localparam int COEF_W = 24;
  localparam int NUM_CH = 16;
  localparam int NUM_SETUP = 8;
  // register offsets
  localparam logic [5:0] CTRL_ADDR = 6'h01;
  localparam logic [5:0] TALLY_ADDR = 6'h08;
  localparam logic [5:0] CHAN_BASE = 6'h09;
  localparam logic [5:0] CFG_BASE = 6'h19;
  localparam logic [5:0] OFFS_BASE = 6'h29;
  localparam logic [5:0] GAIN_BASE = 6'h31;
  // reset values
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [7:0] TALLY_RESET = 8'h00;
  localparam logic [15:0] CHAN_RESET = 16'h0001;
  localparam logic [15:0] CFG_RESET = 16'h0860;
  localparam logic [23:0] OFFS_RESET = 24'h800000;
  localparam logic [23:0] GAIN_RESET = 24'h500000;
  // channel register fields
  localparam int CH_EN_BIT = 15;
  localparam int CH_SETUP_LSB = 12;
  localparam int CH_POS_LSB = 5;
  localparam int CH_NEG_LSB = 0;
  localparam logic [15:0] CH_WMASK = 16'hF3FF;
  // configuration register fields
  localparam int CFG_BUFP_BIT = 6;
  localparam int CFG_BUFM_BIT = 5;
  localparam int CFG_GAIN_LSB = 0;
  localparam logic [15:0] CFG_WMASK = 16'h0FFF;
  // control register mode field and unity gain code
  localparam int CTRL_MODE_LSB = 2;
  localparam logic [3:0] MODE_CONT = 4'h0;
  localparam logic [3:0] MODE_IDLE = 4'h4;
  localparam logic [3:0] MODE_INT_ZERO = 4'h5;
  localparam logic [3:0] MODE_INT_FULL = 4'h6;
  localparam logic [3:0] MODE_SYS_ZERO = 4'h7;
  localparam logic [3:0] MODE_SYS_FULL = 4'h8;
  localparam logic [2:0] GAIN_UNITY = 3'h0;
  // read pipeline depth in cycles
  localparam int READ_LATENCY = 2;
endpackage

// >>> design/acs_coef_mem.sv
// per-setup coefficient store, one write port and two registered read ports
`timescale 1ns/1ps
`default_nettype none
module acs_coef_mem #(
  parameter logic [23:0] RESET_VALUE = 24'h000000
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [2:0] wr_addr,
  input wire logic [23:0] wr_data,
  input wire logic [2:0] rd_addr_a,
  output logic [23:0] rd_data_a,
  input wire logic [2:0] rd_addr_b,
  output logic [23:0] rd_data_b
);
  logic [23:0] mem_q [8];

  // storage with reset to the preset value
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        mem_q[i] <= RESET_VALUE;
      end
    end else if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_data_a <= RESET_VALUE;
      rd_data_b <= RESET_VALUE;
    end else begin
      rd_data_a <= mem_q[rd_addr_a];
      rd_data_b <= mem_q[rd_addr_b];
    end
  end
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// self-checking bench for the channel sequencer and setup logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin failures++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic reg_wr = 1'b0;
  logic [23:0] reg_wdata = 24'h000000;
  logic reg_rd = 1'b0;
  logic [23:0] reg_rdata;
  logic reg_rvalid;
  logic conv_done = 1'b0;
  logic cal_done = 1'b0;
  logic [23:0] cal_result = 24'h000000;
  logic converting;
  logic [3:0] active_channel;
  logic [4:0] positive_input_select;
  logic [4:0] negative_input_select;
  logic [2:0] active_setup;
  logic [2:0] gain_select;
  logic positive_buffer_on;
  logic negative_buffer_on;
  logic gain_stage_on;
  logic [23:0] offset_coef;
  logic [23:0] gain_coef;
  int failures = 0;
  int n_compared = 0;
  logic [15:0] ch [16];
  logic [15:0] cfg [8];
  logic [23:0] off [8];
  logic [23:0] gn [8];

  always #2.5 mclk = ~mclk;

  acs_sequencer u_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .conv_done(conv_done), .cal_done(cal_done), .cal_result(cal_result), .converting(converting),
    .active_channel(active_channel), .positive_input_select(positive_input_select),
    .negative_input_select(negative_input_select), .active_setup(active_setup),
    .gain_select(gain_select), .positive_buffer_on(positive_buffer_on),
    .negative_buffer_on(negative_buffer_on), .gain_stage_on(gain_stage_on),
    .offset_coef(offset_coef), .gain_coef(gain_coef));

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [23:0] d);
    d = 'x;
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      #1;
      if (reg_rvalid === 1'b1) begin
        d = reg_rdata;
        break;
      end
    end
  endtask

  task automatic rdchk(input logic [5:0] a, input logic [23:0] ex, input string nm);
    logic [23:0] v;
    rd(a, v);
    `CHK(nm, ex, v)
  endtask

  task automatic pulse_conv;
    @(posedge mclk);
    conv_done <= 1'b1;
    @(posedge mclk);
    conv_done <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic pulse_cal(input logic [23:0] r);
    @(posedge mclk);
    cal_done <= 1'b1;
    cal_result <= r;
    @(posedge mclk);
    cal_done <= 1'b0;
  endtask

  function automatic int next_en(input int c);
    for (int k = 1; k <= 16; k++) begin
      if (ch[(c + k) % 16][15]) return (c + k) % 16;
    end
    return c;
  endfunction

  task automatic chk_out(input int c);
    logic [2:0] s;
    logic [2:0] g;
    logic up;
    s = ch[c][14:12];
    g = cfg[s][2:0];
    up = (g != acs_pkg::GAIN_UNITY);
    `CHK("converting", 1'b1, converting)
    `CHK("active_channel", 4'(c), active_channel)
    `CHK("positive_input_select", ch[c][9:5], positive_input_select)
    `CHK("negative_input_select", ch[c][4:0], negative_input_select)
    `CHK("active_setup", s, active_setup)
    `CHK("gain_select", g, gain_select)
    `CHK("positive_buffer_on", cfg[s][6] | up, positive_buffer_on)
    `CHK("negative_buffer_on", cfg[s][5] | up, negative_buffer_on)
    `CHK("gain_stage_on", up, gain_stage_on)
    `CHK("offset_coef", off[s], offset_coef)
    `CHK("gain_coef", gn[s], gain_coef)
  endtask

  // calibration in mode m lands in the offset (zero) or gain store of setup s
  task automatic cal_step(input logic [3:0] m, input logic zero, input logic [2:0] s);
    logic [23:0] r;
    r = 24'($urandom);
    wr(acs_pkg::CTRL_ADDR, 24'(m) << acs_pkg::CTRL_MODE_LSB);
    pulse_cal(r);
    if (zero) begin
      off[s] = r;
      rdchk(acs_pkg::OFFS_BASE + 6'(s), r, "cal offset");
    end else begin
      gn[s] = r;
      rdchk(acs_pkg::GAIN_BASE + 6'(s), r, "cal gain");
    end
    rdchk(acs_pkg::CTRL_ADDR, 24'(acs_pkg::MODE_IDLE) << acs_pkg::CTRL_MODE_LSB, "mode after cal");
  endtask

  // sel >= 0 enables that channel alone, otherwise a random set with one forced on
  task automatic run_round(input int sel, input int steps);
    logic [15:0] d;
    int c;
    int f;
    f = $urandom % 16;
    wr(acs_pkg::CTRL_ADDR, 24'h000010);
    for (int i = 0; i < 16; i++) begin
      d = 16'($urandom);
      if (sel >= 0) d[15] = (i == sel);
      else if (i == f) d[15] = 1'b1;
      ch[i] = d & acs_pkg::CH_WMASK;
      wr(acs_pkg::CHAN_BASE + 6'(i), {8'h00, d});
    end
    for (int i = 0; i < 8; i++) begin
      d = 16'($urandom);
      cfg[i] = d & acs_pkg::CFG_WMASK;
      wr(acs_pkg::CFG_BASE + 6'(i), {8'h00, d});
      off[i] = 24'($urandom);
      wr(acs_pkg::OFFS_BASE + 6'(i), off[i]);
      gn[i] = 24'($urandom);
      wr(acs_pkg::GAIN_BASE + 6'(i), gn[i]);
    end
    rdchk(acs_pkg::CHAN_BASE + 6'(f), {8'h00, ch[f]}, "channel reg");
    rdchk(acs_pkg::CFG_BASE + 6'(f % 8), {8'h00, cfg[f % 8]}, "config reg");
    wr(acs_pkg::CTRL_ADDR, 24'h000000);
    repeat (4) @(posedge mclk);
    #1;
    c = next_en(15);
    chk_out(c);
    for (int i = 0; i < steps; i++) begin
      pulse_conv();
      c = next_en(c);
      chk_out(c);
    end
  endtask

  initial begin
    #100000;
    failures++;
    report_and_stop();
  end

  initial begin
    logic [23:0] t1;
    logic [23:0] t2;
    logic [2:0] s;
    void'($urandom(95419));
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    rdchk(acs_pkg::CTRL_ADDR, {8'h00, acs_pkg::CTRL_RESET}, "ctrl reset");
    rdchk(acs_pkg::CHAN_BASE + 6'h0F, {8'h00, acs_pkg::CHAN_RESET}, "channel reset");
    rdchk(acs_pkg::CFG_BASE + 6'h07, {8'h00, acs_pkg::CFG_RESET}, "config reset");
    for (int k = 0; k < 8; k++) begin
      rdchk(acs_pkg::OFFS_BASE + 6'(k), acs_pkg::OFFS_RESET, "offset reset");
    end
    rdchk(6'h39, 24'h000000, "unmapped read");
    `CHK("idle converting", 1'b0, converting)
    rd(acs_pkg::TALLY_ADDR, t1);
    rd(acs_pkg::TALLY_ADDR, t2);
    // the two read requests are sampled three edges apart
    `CHK("tally step", 8'h03, 8'(t2 - t1))
    run_round(-1, 40);
    run_round(-1, 40);
    run_round(7, 5);
    s = ch[7][14:12];
    cal_step(acs_pkg::MODE_INT_ZERO, 1'b1, s);
    cal_step(acs_pkg::MODE_INT_FULL, 1'b0, s);
    cal_step(acs_pkg::MODE_SYS_ZERO, 1'b1, s);
    cal_step(acs_pkg::MODE_SYS_FULL, 1'b0, s);
    // a calibration pulse outside a calibration mode leaves the offset alone
    pulse_cal(24'($urandom));
    rdchk(acs_pkg::OFFS_BASE + 6'(s), off[s], "offset kept idle");
    wr(acs_pkg::CTRL_ADDR, 24'h000000);
    repeat (4) @(posedge mclk);
    #1;
    chk_out(7);
    report_and_stop();
  end
endmodule
`default_nettype wire
